// File: hdl/fwp_protect.sv
// Purpose: write-protect decision and lock bits of a 1 MB serial flash array
// Assumes: commands arrive as register writes on classic Wishbone
// Notes: the serial command framing lives outside this block
//
// Behaviour
// - select bit clear: decide by range fields (complement, size, direction, extent)
// - select bit set: ignore range fields, use per-block lock bits
// - complement set inverts the range result
// - granularity picks 4 kB or 64 kB extent units
// - direction bit: range grows from zero or down from top
// - reject program or erase hitting the extent-protected region
// - 64 kB units: 1..4 give 64..512 kB, 5..7 all, 0 none
// - 4 kB units: 1..3 give 4..16 kB, 4..5 32 kB, 6..7 all
// - complement: 0 protects all, partials inverted, all becomes none
// - complement, 4 kB units: 32 kB erase checked on 32 kB-aligned range
// - complement, 4 kB units: 64 kB erase checked on 64 kB-aligned range
// - addresses outside the selected range stay open
// - lock command with address sets that block's lock bit
// - unlock command clears the addressed lock bit; host unlocks areas
// - all lock bits come up set
// - 46 lock bits: 4 kB in blocks 0 and 15, 64 kB otherwise
// - global lock sets and global unlock clears all bits at once
// - reset selects range scheme with nothing protected
// - lock read returns 8-bit field MSB first, LSB is the lock
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fwp_cfg.svh"

module fwp_protect (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // array sequencer
  output logic ARRAY_START,
  output logic [2:0] ARRAY_KIND,
  output logic [23:0] ARRAY_ADDR,
  // lock field serial out
  output logic LOCK_SO,
  output logic LOCK_SO_VALID
);

  // lock bit number of a 4 kB unit
  function automatic logic [5:0] lock_index(input logic [7:0] unit);
    logic [5:0] idx;
    begin
      if (unit[7:4] == 4'h0) begin
        idx = {2'h0, unit[3:0]};
      end else if (unit[7:4] == 4'hF) begin
        idx = {2'h1, unit[3:0]};
      end else begin
        idx = 6'h1F + {2'h0, unit[7:4]};
      end
      return idx;
    end
  endfunction

  // any lock bit set over a span of 4 kB units
  function automatic logic span_locked(input logic [45:0] locks, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic hit;
    begin
      hit = 1'b0;
      for (int i = 0; i < 256; i++) begin
        if (8'(i) >= lo && 8'(i) <= hi && locks[lock_index(8'(i))]) begin
          hit = 1'b1;
        end
      end
      return hit;
    end
  endfunction

  // range scheme verdict for a span of 4 kB units
  function automatic logic range_reject(input logic [2:0] ext, input logic gran,
                                        input logic bot, input logic cmp,
                                        input logic shrink_ok,
                                        input logic [7:0] glo, input logic [7:0] ghi);
    logic [8:0] size;
    logic [8:0] lo;
    logic [8:0] hi;
    logic none;
    logic all;
    logic tmp;
    logic rej;
    begin
      none = (ext == 3'h0);
      if (!gran) begin
        all = (ext >= 3'h5);
        size = 9'h010 << 3'(ext - 3'h1);
      end else begin
        all = (ext >= 3'h6);
        size = (ext >= 3'h4) ? 9'h008 : (9'h001 << 3'(ext - 3'h1));
      end
      if (bot) begin
        lo = 9'h000;
        hi = 9'(size - 9'h001);
      end else begin
        lo = 9'(9'h100 - size);
        hi = 9'h0FF;
      end
      if (cmp) begin
        tmp = none;
        none = all;
        all = tmp;
        if (bot) begin
          lo = 9'(hi + 9'h001);
          hi = 9'h0FF;
        end else begin
          hi = 9'(lo - 9'h001);
          lo = 9'h000;
        end
      end
      if (none) begin
        rej = 1'b0;
      end else if (all) begin
        rej = 1'b1;
      end else if (cmp && gran && shrink_ok) begin
        // only erase granules lying wholly inside count
        rej = ({1'b0, glo} >= lo) && ({1'b0, ghi} <= hi);
      end else begin
        rej = ({1'b0, glo} <= hi) && ({1'b0, ghi} >= lo);
      end
      return rej;
    end
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] din,
                                             input logic [3:0] sel);
    logic [31:0] res;
    begin
      res = old;
      for (int b = 0; b < 4; b++) begin
        if (sel[b]) begin
          res[8*b +: 8] = din[8*b +: 8];
        end
      end
      return res;
    end
  endfunction

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_reg;

  // state
  logic [2:0] extent_reg, extent_next;
  logic bottom_reg, bottom_next;
  logic gran_reg, gran_next;
  logic compl_reg, compl_next;
  logic scheme_reg, scheme_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0] lastop_reg, lastop_next;
  logic rej_reg, rej_next;
  logic go_reg, go_next;
  logic [7:0] lockfld_reg, lockfld_next;
  logic [45:0] locks_reg, locks_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic start_reg, start_next;
  logic [2:0] kind_reg, kind_next;
  logic [23:0] aaddr_reg, aaddr_next;
  fwp_pkg::fwp_shift_type sh_reg, sh_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] shcnt_reg, shcnt_next;

  // bus access completes on the ack edge
  logic acc;
  logic wr;
  logic [31:0] cur;
  logic [31:0] wv;
  logic [7:0] op;
  logic is_arr;
  fwp_pkg::fwp_arr_type kind;
  logic [7:0] glo;
  logic [7:0] ghi;
  logic verdict;

  always_comb begin
    acc = WB_CYC_I && WB_STB_I && !ack_reg;
    wr = acc && WB_WE_I;
    extent_next = extent_reg;
    bottom_next = bottom_reg;
    gran_next = gran_reg;
    compl_next = compl_reg;
    scheme_next = scheme_reg;
    addr_next = addr_reg;
    lastop_next = lastop_reg;
    rej_next = rej_reg;
    go_next = go_reg;
    lockfld_next = lockfld_reg;
    locks_next = locks_reg;
    ack_next = acc;
    rdata_next = rdata_reg;
    start_next = 1'b0;
    kind_next = kind_reg;
    aaddr_next = aaddr_reg;
    sh_next = sh_reg;
    shift_next = shift_reg;
    shcnt_next = shcnt_reg;
    is_arr = 1'b0;
    kind = fwp_pkg::FWP_ARR_PROG;
    glo = addr_reg[19:12];
    ghi = addr_reg[19:12];
    verdict = 1'b0;
    op = WB_DAT_I[7:0];

    // register read image
    cur = 32'h0000_0000;
    case (WB_ADR_I)
      `FWP_OFS_STAT1: begin
        cur[`FWP_EXTENT_MSB:`FWP_EXTENT_LSB] = extent_reg;
        cur[`FWP_BOTTOM_BIT] = bottom_reg;
        cur[`FWP_GRAN_BIT] = gran_reg;
      end
      `FWP_OFS_STAT2: cur[`FWP_COMPL_BIT] = compl_reg;
      `FWP_OFS_STAT3: cur[`FWP_SCHEME_BIT] = scheme_reg;
      `FWP_OFS_ADDR: cur[23:0] = addr_reg;
      `FWP_OFS_CMD: cur[7:0] = lastop_reg;
      `FWP_OFS_RESULT: begin
        cur[`FWP_RES_REJ_BIT] = rej_reg;
        cur[`FWP_RES_GO_BIT] = go_reg;
        cur[`FWP_RES_LOCK_BIT] = lockfld_reg[0];
      end
      `FWP_OFS_LOCKFLD: cur[7:0] = lockfld_reg;
      default: cur = 32'h0000_0000;
    endcase
    if (acc && !WB_WE_I) begin
      rdata_next = cur;
    end
    wv = lane_merge(cur, WB_DAT_I, WB_SEL_I);

    // serial lock field shifter
    case (sh_reg)
      fwp_pkg::FWP_SH_IDLE: sh_next = fwp_pkg::FWP_SH_IDLE;
      fwp_pkg::FWP_SH_SHIFT: begin
        shift_next = {shift_reg[6:0], 1'b0};
        shcnt_next = 4'(shcnt_reg - 4'h1);
        if (shcnt_reg == 4'h1) begin
          sh_next = fwp_pkg::FWP_SH_IDLE;
        end
      end
      default: sh_next = fwp_pkg::FWP_SH_IDLE;
    endcase

    if (wr) begin
      case (WB_ADR_I)
        `FWP_OFS_STAT1: begin
          extent_next = wv[`FWP_EXTENT_MSB:`FWP_EXTENT_LSB];
          bottom_next = wv[`FWP_BOTTOM_BIT];
          gran_next = wv[`FWP_GRAN_BIT];
        end
        `FWP_OFS_STAT2: compl_next = wv[`FWP_COMPL_BIT];
        `FWP_OFS_STAT3: scheme_next = wv[`FWP_SCHEME_BIT];
        `FWP_OFS_ADDR: addr_next = wv[23:0];
        `FWP_OFS_CMD: begin
          if (WB_SEL_I[0]) begin
            lastop_next = op;
            case (op)
              `FWP_OP_LOCK: locks_next[lock_index(addr_reg[19:12])] = 1'b1;
              `FWP_OP_UNLOCK: locks_next[lock_index(addr_reg[19:12])] = 1'b0;
              `FWP_OP_GLOCK: locks_next = {46{1'b1}};
              `FWP_OP_GUNLOCK: locks_next = {46{1'b0}};
              `FWP_OP_RDLOCK_A, `FWP_OP_RDLOCK_B: begin
                lockfld_next = {7'h00, locks_reg[lock_index(addr_reg[19:12])]};
                shift_next = {7'h00, locks_reg[lock_index(addr_reg[19:12])]};
                shcnt_next = `FWP_LOCKFLD_BITS;
                sh_next = fwp_pkg::FWP_SH_SHIFT;
              end
              `FWP_OP_PROG: begin
                is_arr = 1'b1;
                kind = fwp_pkg::FWP_ARR_PROG;
              end
              `FWP_OP_E4K: begin
                is_arr = 1'b1;
                kind = fwp_pkg::FWP_ARR_E4K;
              end
              `FWP_OP_E32K: begin
                is_arr = 1'b1;
                kind = fwp_pkg::FWP_ARR_E32K;
                glo = {addr_reg[19:15], 3'h0};
                ghi = {addr_reg[19:15], 3'h7};
              end
              `FWP_OP_E64K: begin
                is_arr = 1'b1;
                kind = fwp_pkg::FWP_ARR_E64K;
                glo = {addr_reg[19:16], 4'h0};
                ghi = {addr_reg[19:16], 4'hF};
              end
              `FWP_OP_CHIP_A, `FWP_OP_CHIP_B: begin
                is_arr = 1'b1;
                kind = fwp_pkg::FWP_ARR_CHIP;
                glo = 8'h00;
                ghi = 8'hFF;
              end
              default: is_arr = 1'b0;
            endcase
          end
        end
        default: is_arr = 1'b0;
      endcase
    end

    // scheme select decides which map applies
    if (scheme_reg) begin
      verdict = span_locked(locks_reg, glo, ghi);
    end else begin
      verdict = range_reject(extent_reg, gran_reg, bottom_reg, compl_reg,
                             (kind == fwp_pkg::FWP_ARR_E32K) ||
                             (kind == fwp_pkg::FWP_ARR_E64K), glo, ghi);
    end
    if (is_arr) begin
      rej_next = verdict;
      go_next = !verdict;
      if (!verdict) begin
        // a refused command never reaches the sequencer
        start_next = 1'b1;
        kind_next = kind;
        aaddr_next = addr_reg;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      extent_reg <= `FWP_EXTENT_RST;
      bottom_reg <= `FWP_BOTTOM_RST;
      gran_reg <= `FWP_GRAN_RST;
      compl_reg <= `FWP_COMPL_RST;
      scheme_reg <= `FWP_SCHEME_RST;
      addr_reg <= 24'h00_0000;
      lastop_reg <= 8'h00;
      rej_reg <= 1'b0;
      go_reg <= 1'b0;
      lockfld_reg <= 8'h00;
      locks_reg <= `FWP_LOCKS_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      start_reg <= 1'b0;
      kind_reg <= 3'h0;
      aaddr_reg <= 24'h00_0000;
      sh_reg <= fwp_pkg::FWP_SH_IDLE;
      shift_reg <= 8'h00;
      shcnt_reg <= 4'h0;
    end else begin
      extent_reg <= extent_next;
      bottom_reg <= bottom_next;
      gran_reg <= gran_next;
      compl_reg <= compl_next;
      scheme_reg <= scheme_next;
      addr_reg <= addr_next;
      lastop_reg <= lastop_next;
      rej_reg <= rej_next;
      go_reg <= go_next;
      lockfld_reg <= lockfld_next;
      locks_reg <= locks_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      kind_reg <= kind_next;
      aaddr_reg <= aaddr_next;
      sh_reg <= sh_next;
      shift_reg <= shift_next;
      shcnt_reg <= shcnt_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;
  assign ARRAY_START = start_reg;
  assign ARRAY_KIND = kind_reg;
  assign ARRAY_ADDR = aaddr_reg;
  assign LOCK_SO = shift_reg[7];
  assign LOCK_SO_VALID = (sh_reg == fwp_pkg::FWP_SH_SHIFT);

endmodule

`default_nettype wire

// File: include/fwp_cfg.svh
// Purpose: offsets, field positions, reset values and opcodes of the protect block
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: definitions only
`ifndef FWP_CFG_SVH
`define FWP_CFG_SVH

// register byte offsets
`define FWP_OFS_STAT1 8'h00
`define FWP_OFS_STAT2 8'h04
`define FWP_OFS_STAT3 8'h08
`define FWP_OFS_ADDR 8'h0C
`define FWP_OFS_CMD 8'h10
`define FWP_OFS_RESULT 8'h14
`define FWP_OFS_LOCKFLD 8'h18

// field positions
`define FWP_EXTENT_LSB 2
`define FWP_EXTENT_MSB 4
`define FWP_BOTTOM_BIT 5
`define FWP_GRAN_BIT 6
`define FWP_COMPL_BIT 6
`define FWP_SCHEME_BIT 2
`define FWP_RES_REJ_BIT 0
`define FWP_RES_GO_BIT 1
`define FWP_RES_LOCK_BIT 2

// reset values
`define FWP_EXTENT_RST 3'h0
`define FWP_BOTTOM_RST 1'h0
`define FWP_GRAN_RST 1'h0
`define FWP_COMPL_RST 1'h0
`define FWP_SCHEME_RST 1'h0
`define FWP_LOCKS_RST 46'h3FFF_FFFF_FFFF

// opcodes
`define FWP_OP_LOCK 8'h36
`define FWP_OP_UNLOCK 8'h39
`define FWP_OP_GLOCK 8'h7E
`define FWP_OP_GUNLOCK 8'h98
`define FWP_OP_RDLOCK_A 8'h3C
`define FWP_OP_RDLOCK_B 8'h3D
`define FWP_OP_PROG 8'h02
`define FWP_OP_E4K 8'h20
`define FWP_OP_E32K 8'h52
`define FWP_OP_E64K 8'hD8
`define FWP_OP_CHIP_A 8'h60
`define FWP_OP_CHIP_B 8'hC7

// lock field shift length
`define FWP_LOCKFLD_BITS 4'h8

`endif

// File: include/fwp_pkg.sv
// Purpose: types of the flash write-protect block
// Assumes: nothing
// Notes: used by scoped name only
package fwp_pkg;

  typedef enum logic [2:0] {
    FWP_ARR_PROG = 3'h0,
    FWP_ARR_E4K = 3'h1,
    FWP_ARR_E32K = 3'h2,
    FWP_ARR_E64K = 3'h3,
    FWP_ARR_CHIP = 3'h4
  } fwp_arr_type;

  typedef enum logic [1:0] {
    FWP_SH_IDLE = 2'h1,
    FWP_SH_SHIFT = 2'h2
  } fwp_shift_type;

endpackage

// File: verification/fwp_protect_asserts.sv
// Purpose: concurrent checks on the ports of the flash write-protect block
// Assumes: one clock, reset active low, classic wishbone single cycles
// Notes: bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
`include "fwp_cfg.svh"

module fwp_protect_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // array sequencer and lock field
  input wire logic ARRAY_START,
  input wire logic [2:0] ARRAY_KIND,
  input wire logic [23:0] ARRAY_ADDR,
  input wire logic LOCK_SO,
  input wire logic LOCK_SO_VALID
);
  logic bus_req;
  logic cmd_req;
  logic pe_op;
  logic rd_op;
  logic [2:0] kind_exp;

  always_comb begin
    bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    cmd_req = bus_req && WB_WE_I && (WB_ADR_I == `FWP_OFS_CMD) && WB_SEL_I[0];
    rd_op = (WB_DAT_I[7:0] == `FWP_OP_RDLOCK_A) || (WB_DAT_I[7:0] == `FWP_OP_RDLOCK_B);
    pe_op = 1'b1;
    kind_exp = fwp_pkg::FWP_ARR_PROG;
    case (WB_DAT_I[7:0])
      `FWP_OP_PROG: kind_exp = fwp_pkg::FWP_ARR_PROG;
      `FWP_OP_E4K: kind_exp = fwp_pkg::FWP_ARR_E4K;
      `FWP_OP_E32K: kind_exp = fwp_pkg::FWP_ARR_E32K;
      `FWP_OP_E64K: kind_exp = fwp_pkg::FWP_ARR_E64K;
      `FWP_OP_CHIP_A, `FWP_OP_CHIP_B: kind_exp = fwp_pkg::FWP_ARR_CHIP;
      default: pe_op = 1'b0;
    endcase
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // restart during a frame stretches it past eight cycles and fails chk_field_frame; never driven by the bench
  sequence s_field_frame;
    LOCK_SO_VALID [*8] ##1 !LOCK_SO_VALID;
  endsequence
  sequence s_lead_zeros;
    !LOCK_SO [*7];
  endsequence

  chk_ack_follows: assert property (bus_req |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_start_cause: assert property (ARRAY_START |-> WB_ACK_O && $past(cmd_req && pe_op))
    else $error("array start without program or erase command");
  chk_start_kind: assert property (ARRAY_START |-> ARRAY_KIND == $past(kind_exp))
    else $error("array kind does not match opcode");
  chk_target_hold: assert property (!ARRAY_START |-> $stable(ARRAY_KIND) && $stable(ARRAY_ADDR))
    else $error("array target changed without a grant");
  chk_field_frame: assert property ($rose(LOCK_SO_VALID) |-> s_field_frame)
    else $error("lock field frame not eight cycles");
  chk_field_zeros: assert property ($rose(LOCK_SO_VALID) |-> s_lead_zeros)
    else $error("lock field upper bits not zero");
  chk_field_cause: assert property ($rose(LOCK_SO_VALID) |-> WB_ACK_O && $past(cmd_req && rd_op))
    else $error("lock field sent without lock read");
endmodule

bind fwp_protect fwp_protect_asserts i_chk (
  .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .ARRAY_START(ARRAY_START), .ARRAY_KIND(ARRAY_KIND),
  .ARRAY_ADDR(ARRAY_ADDR), .LOCK_SO(LOCK_SO), .LOCK_SO_VALID(LOCK_SO_VALID)
);
`default_nettype wire

// File: verification/fwp_seq_model.sv
// Purpose: array sequencer and lock field receiver behind the protect block
// Assumes: granted commands arrive as a one-cycle start pulse
// Notes: no erase timing modelled; only what the bench compares
`timescale 1ns/100ps
`default_nettype none

module fwp_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // from the protect block
  input wire logic array_start,
  input wire logic [23:0] array_addr,
  input wire logic lock_so,
  input wire logic lock_so_valid,
  // seen by the bench
  output logic [23:0] addr_seen,
  output logic [7:0] field_seen
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_seen <= 24'h00_0000;
      field_seen <= 8'h00;
    end else begin
      if (array_start) begin
        addr_seen <= array_addr;
      end
      // eight shifts leave the whole field, msb first
      if (lock_so_valid) begin
        field_seen <= {field_seen[6:0], lock_so};
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/fwp_protect_tb_top.sv
// Purpose: self-checking bench of the flash write-protect block
// Assumes: 40 MHz clock, classic wishbone single cycles
// Notes: each table row sets the protect fields, aims one command, checks the outcome
`timescale 1ns/100ps
`default_nettype none
`include "fwp_cfg.svh"

module fwp_protect_tb_top;
  logic clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic ack;
  logic start;
  logic [2:0] kind;
  logic [23:0] taddr;
  logic so;
  logic so_vld;
  logic [7:0] fld;
  logic [23:0] seen_addr;
  logic last_start;
  logic [31:0] rd;
  int error_cnt;
  int comparisons;
  // stat1, stat2, stat3, opcode, target, grant expected or lock field
  localparam logic [63:0] TV [0:47] = '{
    64'h00_00_00_02_0FFFFF_01, 64'h00_00_00_60_000000_01, 64'h04_00_00_02_0F0000_00,
    64'h04_00_00_02_0EFFFF_01, 64'h30_00_00_02_07FFFF_00, 64'h30_00_00_02_080000_01,
    64'h14_00_00_D8_000000_00, 64'h44_00_00_02_0FF000_00, 64'h44_00_00_20_0FE000_01,
    64'h74_00_00_02_007FFF_00, 64'h74_00_00_52_008000_01, 64'h58_00_00_02_000000_00,
    64'h04_00_00_60_000000_00, 64'h00_40_00_02_0FFFFF_00, 64'h04_40_00_02_0EFFFF_00,
    64'h04_40_00_02_0F0000_01, 64'h14_40_00_02_000000_01, 64'h44_40_00_02_0FEFFF_00,
    64'h44_40_00_02_0FF000_01, 64'h44_40_00_52_0F8000_01, 64'h44_40_00_52_0F0000_00,
    64'h44_40_00_D8_0F0000_01, 64'h64_40_00_52_000000_01, 64'h64_40_00_D8_000000_01,
    64'h64_40_00_20_001000_00, 64'h64_40_00_20_000000_01, 64'h18_00_04_02_050000_00,
    64'h18_00_04_3C_050000_01, 64'h18_00_04_98_000000_00, 64'h18_00_04_02_050000_01,
    64'h18_00_04_36_003000_00, 64'h18_00_04_02_003FFF_00, 64'h18_00_04_02_004000_01,
    64'h18_00_04_36_0F5123_00, 64'h18_00_04_02_0F5000_00, 64'h18_00_04_02_0F6000_01,
    64'h18_00_04_36_030000_00, 64'h18_00_04_02_03FFFF_00, 64'h18_00_04_02_040000_01,
    64'h18_00_04_3D_030000_01, 64'h18_00_04_3D_040000_00, 64'h18_00_04_39_003000_00,
    64'h18_00_04_02_003000_01, 64'h18_00_04_D8_0F0000_00, 64'h18_00_04_7E_000000_00,
    64'h18_00_04_02_080000_00, 64'h00_00_00_02_080000_01, 64'h00_00_00_C7_000000_01
  };

  fwp_protect i_dut (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .ARRAY_START(start),
    .ARRAY_KIND(kind), .ARRAY_ADDR(taddr), .LOCK_SO(so), .LOCK_SO_VALID(so_vld)
  );

  fwp_seq_model i_seq (
    .clk(clk), .rst_n(rst_n), .array_start(start), .array_addr(taddr), .lock_so(so),
    .lock_so_valid(so_vld), .addr_seen(seen_addr), .field_seen(fld)
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // start arrives with the ack, so it is taken at the same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = dat_r;
    last_start = start;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      cmp("wb_ack", 32'h1, 32'h0);
      end_sim();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    logic [63:0] v;
    logic pe;
    int k;
    logic [2:0] kx;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    error_cnt = 0;
    comparisons = 0;
    last_start = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 3; k++) begin
      wb(1'b0, 8'(4 * k), 4'hF, 32'h0);
      cmp("status_reset", 32'h0, rd);
    end
    wb(1'b1, 8'h1C, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 4'hF, 32'h0);
    cmp("unmapped", 32'h0, rd);
    wb(1'b1, `FWP_OFS_STAT2, 4'h0, 32'h40);
    wb(1'b0, `FWP_OFS_STAT2, 4'hF, 32'h0);
    cmp("stat2_nosel", 32'h0, rd);
    for (int i = 0; i < 48; i++) begin
      v = TV[i];
      pe = v[39:32] inside {`FWP_OP_PROG, `FWP_OP_E4K, `FWP_OP_E32K, `FWP_OP_E64K,
                            `FWP_OP_CHIP_A, `FWP_OP_CHIP_B};
      wb(1'b1, `FWP_OFS_STAT1, 4'hF, {24'h0, v[63:56]});
      wb(1'b1, `FWP_OFS_STAT2, 4'hF, {24'h0, v[55:48]});
      wb(1'b1, `FWP_OFS_STAT3, 4'hF, {24'h0, v[47:40]});
      wb(1'b1, `FWP_OFS_ADDR, 4'hF, {8'h0, v[31:8]});
      wb(1'b1, `FWP_OFS_CMD, 4'hF, {24'h0, v[39:32]});
      if (v[39:32] == `FWP_OP_RDLOCK_A || v[39:32] == `FWP_OP_RDLOCK_B) begin
        k = 0;
        while (so_vld !== 1'b0 && k < 20) begin
          @(posedge clk);
          k++;
        end
        if (k >= 20) begin
          cmp("field_end", 32'h0, 32'h1);
          end_sim();
        end
        cmp("lock_field", {24'h0, v[7:0]}, {24'h0, fld});
        wb(1'b0, `FWP_OFS_LOCKFLD, 4'hF, 32'h0);
        cmp("lockfld_reg", {24'h0, v[7:0]}, rd);
        wb(1'b0, `FWP_OFS_RESULT, 4'hF, 32'h0);
        cmp("result_lock", {31'h0, v[0]}, {31'h0, rd[2]});
      end else begin
        cmp("array_start", {31'h0, v[0]}, {31'h0, last_start});
      end
      if (pe) begin
        wb(1'b0, `FWP_OFS_RESULT, 4'hF, 32'h0);
        cmp("result", v[0] ? 32'h2 : 32'h1, {30'h0, rd[1:0]});
      end
      if (pe && v[0]) begin
        cmp("target", {12'h0, v[27:8]}, {12'h0, seen_addr[19:0]});
        case (v[39:32])
          `FWP_OP_PROG: kx = fwp_pkg::FWP_ARR_PROG;
          `FWP_OP_E4K: kx = fwp_pkg::FWP_ARR_E4K;
          `FWP_OP_E32K: kx = fwp_pkg::FWP_ARR_E32K;
          `FWP_OP_E64K: kx = fwp_pkg::FWP_ARR_E64K;
          default: kx = fwp_pkg::FWP_ARR_CHIP;
        endcase
        cmp("kind", {29'h0, kx}, {29'h0, kind});
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
